/* logic/bsd_top.sv */
// Boundary-scan test logic: instruction and data registers, pin cells
//////////////////////////////////////////////////////////////////////
// What this block does
// - Bypass is one stage, cleared on leaving Capture-DR when selected.
// - Identity word holds a 4-bit version, first revision 0x0.
// - Identity word holds a 16-bit part number.
// - Identity word holds an 11-bit maker code.
// - Opcode 0x1 picks the 32-bit identity word; default after reset.
// - A one in the reset register holds the chip in reset.
// - Reset register drives reset directly, with no update latch.
// - After release, reset stays for the fuse-chosen time-out.
// - Instruction register is 4 bits, up to 16 opcodes.
// - Every shift register moves its least significant bit first.
// - Opcode 0x0 drives latched chain outputs on pins once loaded.
// - EXTEST captures pins, shifts chain, updates output latches.
// - Opcode 0x2 samples pins and preloads latches without driving pins.
// - Opcode 0xC picks the reset register, shift only; TAP untouched.
// - Opcode 0xF picks bypass; capture loads zero, shift moves it.
// - No high-impedance opcode; chip reset tri-states the port pins outside EXTEST.
// - Each pin has a pull-up cell plus two-stage pin cell.
// - Cells map to pin input, output bit, direction and pull-up term.
// - Reset pin has two observe cells: normal and high-voltage.
// - Each external oscillator has enable cell and observed clock.
// - Unused scanned clocks read 0 external, 1 for crystals.
// - Port works only with fuse set and disable bit clear.
// - Scan runs on clk_in, sampling the test clock, which must be well below clk_in.
//////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
`include "bsd_map.svh"
module bsd_top
    import bsd_pkg::*;
#(
    parameter int NPIN = 8,
    parameter logic [3:0] ID_VER = 4'h0,
    parameter logic [15:0] ID_PART = 16'h5a5a, // Arbitrary value
    parameter logic [10:0] ID_MFR = 11'h2a5, // Arbitrary value
    parameter logic [15:0] TOUT_0 = `BSD_TOUT_0,
    parameter logic [15:0] TOUT_1 = `BSD_TOUT_1,
    parameter logic [15:0] TOUT_2 = `BSD_TOUT_2,
    parameter logic [15:0] TOUT_3 = `BSD_TOUT_3
)
(
    // Clock, reset, enable
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // Test access port pins
    input wire logic tck_in,
    input wire logic tms_in,
    input wire logic tdi_in,
    output logic tdo_out,
    output logic tdo_oe_out,
    // Port enable fuse and disable bit
    input wire logic test_port_enable_fuse_in,
    input wire logic test_port_disable_bit_in,
    // Clock option fuses
    input wire logic [1:0] clk_opt_in,
    // Port logic
    input wire logic [NPIN-1:0] pin_direction_bit_in,
    input wire logic [NPIN-1:0] pin_output_bit_in,
    input wire logic global_pullup_disable_in,
    // Port pads
    input wire logic [NPIN-1:0] pin_input_bit_in,
    output logic [NPIN-1:0] pin_oe_out,
    output logic [NPIN-1:0] pin_do_out,
    output logic [NPIN-1:0] pin_pu_out,
    // Reset pin
    input wire logic ext_reset_n_in,
    input wire logic high_voltage_reset_in,
    // Oscillators
    input bsd_osc_t osc_en_in,
    input wire logic external_clock_line_in,
    input wire logic crystal_oscillator_clock_in,
    input wire logic low_freq_crystal_clock_in,
    output bsd_osc_t osc_en_out,
    // Chip reset
    output logic chip_reset_out
);

    //////////////////////////////////////////////////////////////////
    // Sizes and synchroniser slots
    localparam int MB = NPIN * `BSD_PIN_CELLS;
    localparam int BSL = MB + `BSD_MISC_CELLS;
    localparam int I_TCK = 0;
    localparam int I_TMS = 1;
    localparam int I_TDI = 2;
    localparam int I_RSTN = 3;
    localparam int I_HV = 4;
    localparam int I_EXT = 5;
    localparam int I_XT = 6;
    localparam int I_LF = 7;
    localparam int I_PIN = 8;
    localparam int SW = I_PIN + NPIN;

    typedef struct packed {
        logic [SW-1:0] s1;
        logic [SW-1:0] s2;
        logic tck_q;
        logic [`BSD_IR_W-1:0] ir_sh;
        bsd_ir_t ir;
        logic bypass;
        logic [31:0] id_sh;
        logic rst_dr;
        logic [BSL-1:0] bs_sh;
        logic [BSL-1:0] bs_upd;
        logic tdo;
        logic tdo_oe;
        logic [NPIN-1:0] pin_oe;
        logic [NPIN-1:0] pin_do;
        logic [NPIN-1:0] pin_pu;
        bsd_osc_t osc;
        logic chip_rst;
        logic [15:0] tout;
    } bsd_top_st_t;

    bsd_top_st_t r_ff;
    bsd_top_st_t nxt_r;

    logic [SW-1:0] raw;
    logic rise;
    logic fall;
    logic tdi;
    logic en;
    logic extest;
    logic src;
    logic dr_lsb;
    logic [15:0] tout_sel;
    logic [31:0] id_val;
    logic [BSL-1:0] cap;
    logic [NPIN-1:0] sys_pu;
    logic [NPIN-1:0] upd_pu;
    logic [NPIN-1:0] upd_oc;
    logic [NPIN-1:0] upd_od;
    bsd_osc_t upd_osc;
    bsd_tap_t tap_st;
    bsd_dr_t sel;

    //////////////////////////////////////////////////////////////////
    // Raw inputs from outside the clock domain
    assign raw = {pin_input_bit_in, low_freq_crystal_clock_in, crystal_oscillator_clock_in,
                  external_clock_line_in, high_voltage_reset_in, ext_reset_n_in, tdi_in, tms_in, tck_in};

    // Test clock edges from the second sync stage
    assign rise = r_ff.s2[I_TCK] & ~r_ff.tck_q;
    assign fall = ~r_ff.s2[I_TCK] & r_ff.tck_q;
    assign tdi = r_ff.s2[I_TDI];
    assign en = test_port_enable_fuse_in & ~test_port_disable_bit_in;
    assign extest = (r_ff.ir == BSD_OP_EXTEST);
    assign sel = bsd_dr_sel(r_ff.ir);
    assign id_val = {ID_VER, ID_PART, ID_MFR, 1'h1};

    // Controller
    bsd_tap u_tap (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .step_in(rise),
        .tms_in(r_ff.s2[I_TMS]),
        .hold_in(~en),
        .state_out(tap_st)
    );

    //////////////////////////////////////////////////////////////////
    // System pull-up term and per-pin cells
    assign sys_pu = ~{NPIN{global_pullup_disable_in}} & ~pin_direction_bit_in & pin_output_bit_in;

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++)
        begin : g_pin
            // Capture side of pull-up and pin cells
            assign cap[gi*`BSD_PIN_CELLS+`BSD_CELL_PU] = sys_pu[gi];
            assign cap[gi*`BSD_PIN_CELLS+`BSD_CELL_OC] = pin_direction_bit_in[gi];
            assign cap[gi*`BSD_PIN_CELLS+`BSD_CELL_DAT] = r_ff.s2[I_PIN+gi];
            // Update latch side
            assign upd_pu[gi] = r_ff.bs_upd[gi*`BSD_PIN_CELLS+`BSD_CELL_PU];
            assign upd_oc[gi] = r_ff.bs_upd[gi*`BSD_PIN_CELLS+`BSD_CELL_OC];
            assign upd_od[gi] = r_ff.bs_upd[gi*`BSD_PIN_CELLS+`BSD_CELL_DAT];
        end
    endgenerate

    // Reset pin observe cells
    assign cap[MB+`BSD_RSTN_OBS] = r_ff.s2[I_RSTN];
    assign cap[MB+`BSD_HV_OBS] = r_ff.s2[I_HV];

    // Oscillator enable and observed clock cells
    assign cap[MB+`BSD_EXT_EN] = osc_en_in.ext_en;
    assign cap[MB+`BSD_EXT_CK] = osc_en_in.ext_en ? r_ff.s2[I_EXT] : `BSD_EXT_IDLE;
    assign cap[MB+`BSD_XT_EN] = osc_en_in.xtal_en;
    assign cap[MB+`BSD_XT_CK] = osc_en_in.xtal_en ? r_ff.s2[I_XT] : `BSD_XT_IDLE;
    assign cap[MB+`BSD_LF_EN] = osc_en_in.lf_en;
    assign cap[MB+`BSD_LF_CK] = osc_en_in.lf_en ? r_ff.s2[I_LF] : `BSD_LF_IDLE;
    assign upd_osc = {r_ff.bs_upd[MB+`BSD_EXT_EN], r_ff.bs_upd[MB+`BSD_XT_EN], r_ff.bs_upd[MB+`BSD_LF_EN]};

    // Selected register bit towards TDO
    always_comb
    begin
        case (sel)
            BSD_DR_ID: dr_lsb = r_ff.id_sh[0];
            BSD_DR_RST: dr_lsb = r_ff.rst_dr;
            BSD_DR_BS: dr_lsb = r_ff.bs_sh[0];
            default: dr_lsb = r_ff.bypass;
        endcase
    end

    // Time-out chosen by clock option fuses
    always_comb
    begin
        case (clk_opt_in)
            2'h0: tout_sel = TOUT_0;
            2'h1: tout_sel = TOUT_1;
            2'h2: tout_sel = TOUT_2;
            default: tout_sel = TOUT_3;
        endcase
    end

    // Reset source: register bit or external pin
    assign src = r_ff.rst_dr | ~r_ff.s2[I_RSTN];

    //////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        nxt_r = r_ff;
        nxt_r.s1 = raw;
        nxt_r.s2 = r_ff.s1;
        nxt_r.tck_q = r_ff.s2[I_TCK];
        // Capture and shift on rising test clock
        if (rise)
        begin
            case (tap_st)
                BSD_TAP_CAP_IR: nxt_r.ir_sh = `BSD_IR_CAPT;
                BSD_TAP_SH_IR: nxt_r.ir_sh = {tdi, r_ff.ir_sh[`BSD_IR_W-1:1]};
                BSD_TAP_CAP_DR:
                begin
                    case (sel)
                        BSD_DR_BYP: nxt_r.bypass = 1'h0;
                        BSD_DR_ID: nxt_r.id_sh = id_val;
                        BSD_DR_BS: nxt_r.bs_sh = cap;
                        default: nxt_r.bypass = r_ff.bypass;
                    endcase
                end
                BSD_TAP_SH_DR:
                begin
                    case (sel)
                        BSD_DR_ID: nxt_r.id_sh = {tdi, r_ff.id_sh[31:1]};
                        BSD_DR_RST: nxt_r.rst_dr = tdi;
                        BSD_DR_BS: nxt_r.bs_sh = {tdi, r_ff.bs_sh[BSL-1:1]};
                        default: nxt_r.bypass = tdi;
                    endcase
                end
                default: nxt_r.ir_sh = r_ff.ir_sh;
            endcase
        end
        // Output and update on falling test clock
        if (fall)
        begin
            nxt_r.tdo_oe = (tap_st == BSD_TAP_SH_IR) | (tap_st == BSD_TAP_SH_DR);
            nxt_r.tdo = (tap_st == BSD_TAP_SH_IR) ? r_ff.ir_sh[0] : dr_lsb;
            if (tap_st == BSD_TAP_UPD_IR)
            begin
                nxt_r.ir = bsd_ir_t'(r_ff.ir_sh);
            end
            if (tap_st == BSD_TAP_TLR)
            begin
                nxt_r.ir = BSD_OP_IDCODE;
            end
            if ((tap_st == BSD_TAP_UPD_DR) && (sel == BSD_DR_BS))
            begin
                nxt_r.bs_upd = r_ff.bs_sh;
            end
        end
        // Port off: TDO not driven, reset register cleared
        if (!en)
        begin
            nxt_r.tdo_oe = 1'h0;
            nxt_r.rst_dr = 1'h0;
        end
        // Reset hold and time-out after release
        nxt_r.tout = src ? tout_sel : ((r_ff.tout != 16'h0) ? r_ff.tout - 16'h1 : r_ff.tout);
        nxt_r.chip_rst = src | (r_ff.tout != 16'h0);
        // Pad control: scan latches under EXTEST, else system, tri-state in reset
        nxt_r.pin_oe = extest ? upd_oc : (r_ff.chip_rst ? '0 : pin_direction_bit_in);
        nxt_r.pin_do = extest ? upd_od : pin_output_bit_in;
        nxt_r.pin_pu = extest ? upd_pu : (r_ff.chip_rst ? '0 : sys_pu);
        nxt_r.osc = extest ? upd_osc : osc_en_in;
    end

    // State register
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            r_ff <= '0;
            r_ff.ir <= BSD_OP_IDCODE;
        end
        else if (ce_in)
        begin
            r_ff <= nxt_r;
        end
    end

    // Outputs straight from the state register
    assign tdo_out = r_ff.tdo;
    assign tdo_oe_out = r_ff.tdo_oe;
    assign pin_oe_out = r_ff.pin_oe;
    assign pin_do_out = r_ff.pin_do;
    assign pin_pu_out = r_ff.pin_pu;
    assign osc_en_out = r_ff.osc;
    assign chip_reset_out = r_ff.chip_rst;

    //////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    property p_byp_cap;
        ce_in && rise && tap_st == BSD_TAP_CAP_DR && sel == BSD_DR_BYP |=> !r_ff.bypass;
    endproperty
    a_byp_cap: assert property (p_byp_cap) else $error("bypass not cleared");

    property p_id_ver;
        ce_in && rise && tap_st == BSD_TAP_CAP_DR && sel == BSD_DR_ID
            |=> r_ff.id_sh[`BSD_ID_VER_LSB+3:`BSD_ID_VER_LSB] == ID_VER;
    endproperty
    a_id_ver: assert property (p_id_ver) else $error("version field wrong");

    property p_id_part;
        ce_in && rise && tap_st == BSD_TAP_CAP_DR && sel == BSD_DR_ID
            |=> r_ff.id_sh[`BSD_ID_PART_LSB+15:`BSD_ID_PART_LSB] == ID_PART
            && r_ff.id_sh[`BSD_ID_MFR_LSB+10:`BSD_ID_MFR_LSB] == ID_MFR;
    endproperty
    a_id_part: assert property (p_id_part) else $error("part or maker field wrong");

    property p_tlr_id;
        ce_in && fall && tap_st == BSD_TAP_TLR |=> r_ff.ir == BSD_OP_IDCODE;
    endproperty
    a_tlr_id: assert property (p_tlr_id) else $error("identity not default");

    property p_rst_hold;
        ce_in && r_ff.rst_dr |=> r_ff.chip_rst;
    endproperty
    a_rst_hold: assert property (p_rst_hold) else $error("chip reset not held");

    property p_rst_tout;
        ce_in && r_ff.tout != 16'h0 |=> r_ff.chip_rst;
    endproperty
    a_rst_tout: assert property (p_rst_tout) else $error("time-out cut short");

    property p_ir_shift;
        ce_in && rise && tap_st == BSD_TAP_SH_IR |=> r_ff.ir_sh[2:0] == $past(r_ff.ir_sh[3:1]);
    endproperty
    a_ir_shift: assert property (p_ir_shift) else $error("shift not lsb first");

    property p_extest_pins;
        ce_in && extest |=> r_ff.pin_oe == $past(upd_oc) && r_ff.pin_do == $past(upd_od);
    endproperty
    a_extest_pins: assert property (p_extest_pins) else $error("latches not on pins");

    property p_sample_quiet;
        ce_in && !extest && !r_ff.chip_rst |=> r_ff.pin_do == $past(pin_output_bit_in);
    endproperty
    a_sample_quiet: assert property (p_sample_quiet) else $error("system pins disturbed");

    property p_rst_tri;
        ce_in && !extest && r_ff.chip_rst |=> r_ff.pin_oe == '0 && r_ff.pin_pu == '0;
    endproperty
    a_rst_tri: assert property (p_rst_tri) else $error("pins not tri-state in reset");

    property p_rstn_obs;
        ce_in && rise && tap_st == BSD_TAP_CAP_DR && sel == BSD_DR_BS
            |=> r_ff.bs_sh[MB+`BSD_RSTN_OBS] == $past(r_ff.s2[I_RSTN]);
    endproperty
    a_rstn_obs: assert property (p_rstn_obs) else $error("reset pin not observed");

    property p_ext_idle;
        ce_in && rise && tap_st == BSD_TAP_CAP_DR && sel == BSD_DR_BS && !osc_en_in.ext_en
            |=> r_ff.bs_sh[MB+`BSD_EXT_CK] == `BSD_EXT_IDLE;
    endproperty
    a_ext_idle: assert property (p_ext_idle) else $error("idle clock line wrong");

    property p_port_off;
        ce_in && !en |=> !r_ff.tdo_oe ##1 !r_ff.rst_dr;
    endproperty
    a_port_off: assert property (p_port_off) else $error("disabled port active");

    c_extest: cover property (ce_in && extest && fall && tap_st == BSD_TAP_UPD_DR);
    c_id_shift: cover property (rise && tap_st == BSD_TAP_SH_DR && sel == BSD_DR_ID);
    c_chip_rst: cover property ($fell(r_ff.rst_dr) ##1 r_ff.chip_rst);
    c_byp_shift: cover property (rise && tap_st == BSD_TAP_SH_DR && sel == BSD_DR_BYP);

endmodule

/* logic/bsd_map.svh */
// Boundary-scan constants: opcodes aside, offsets, fields and counts
`ifndef BSD_MAP_SVH
`define BSD_MAP_SVH

// Instruction register
`define BSD_IR_W 4
`define BSD_IR_CAPT 4'h1

// Identification word field positions
`define BSD_ID_VER_LSB 28
`define BSD_ID_PART_LSB 12
`define BSD_ID_MFR_LSB 1

// Cells per port pin and their order inside a pin group
`define BSD_PIN_CELLS 3
`define BSD_CELL_PU 0
`define BSD_CELL_OC 1
`define BSD_CELL_DAT 2

// Cells after the pin groups
`define BSD_MISC_CELLS 8
`define BSD_RSTN_OBS 0
`define BSD_HV_OBS 1
`define BSD_EXT_EN 2
`define BSD_EXT_CK 3
`define BSD_XT_EN 4
`define BSD_XT_CK 5
`define BSD_LF_EN 6
`define BSD_LF_CK 7

// Scanned clock lines when their source is off
`define BSD_EXT_IDLE 1'h0
`define BSD_XT_IDLE 1'h1
`define BSD_LF_IDLE 1'h1

// Reset time-out counts in clk_in cycles, one per clock option
`define BSD_TOUT_0 16'h0004
`define BSD_TOUT_1 16'h0040
`define BSD_TOUT_2 16'h0400
`define BSD_TOUT_3 16'h1000

`endif

/* logic/bsd_pkg.sv */
// Boundary-scan types: controller states, opcodes, register select, carriers
package bsd_pkg;

    // Sixteen controller states
    typedef enum logic [3:0] {
        BSD_TAP_TLR = 4'h0,
        BSD_TAP_RTI = 4'h1,
        BSD_TAP_SEL_DR = 4'h2,
        BSD_TAP_CAP_DR = 4'h3,
        BSD_TAP_SH_DR = 4'h4,
        BSD_TAP_EX1_DR = 4'h5,
        BSD_TAP_PAU_DR = 4'h6,
        BSD_TAP_EX2_DR = 4'h7,
        BSD_TAP_UPD_DR = 4'h8,
        BSD_TAP_SEL_IR = 4'h9,
        BSD_TAP_CAP_IR = 4'ha,
        BSD_TAP_SH_IR = 4'hb,
        BSD_TAP_EX1_IR = 4'hc,
        BSD_TAP_PAU_IR = 4'hd,
        BSD_TAP_EX2_IR = 4'he,
        BSD_TAP_UPD_IR = 4'hf
    } bsd_tap_t;

    // Public opcodes
    typedef enum logic [3:0] {
        BSD_OP_EXTEST = 4'h0,
        BSD_OP_IDCODE = 4'h1,
        BSD_OP_SAMPLE = 4'h2,
        BSD_OP_CHIP_RESET = 4'hc,
        BSD_OP_BYPASS = 4'hf
    } bsd_ir_t;

    // Data register on the path
    typedef enum logic [1:0] {
        BSD_DR_BYP = 2'h0,
        BSD_DR_ID = 2'h1,
        BSD_DR_RST = 2'h2,
        BSD_DR_BS = 2'h3
    } bsd_dr_t;

    // Oscillator enable group
    typedef struct packed {
        logic ext_en;
        logic xtal_en;
        logic lf_en;
    } bsd_osc_t;

    // Opcode to data register; unknown opcodes fall to bypass
    function automatic bsd_dr_t bsd_dr_sel(input bsd_ir_t op);
        case (op)
            BSD_OP_EXTEST, BSD_OP_SAMPLE: bsd_dr_sel = BSD_DR_BS;
            BSD_OP_IDCODE: bsd_dr_sel = BSD_DR_ID;
            BSD_OP_CHIP_RESET: bsd_dr_sel = BSD_DR_RST;
            default: bsd_dr_sel = BSD_DR_BYP;
        endcase
    endfunction

endpackage

/* logic/bsd_tap.sv */
// Test access port controller state machine
`timescale 1ns/100ps
module bsd_tap
    import bsd_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // Sampled link
    input wire logic step_in,
    input wire logic tms_in,
    input wire logic hold_in,
    // Controller state
    output bsd_tap_t state_out
);

    typedef struct packed {
        bsd_tap_t st;
    } bsd_tap_st_t;

    bsd_tap_st_t r_ff;
    bsd_tap_st_t nxt_r;

    // Next state on each rising test clock
    always_comb
    begin
        nxt_r = r_ff;
        if (hold_in)
        begin
            nxt_r.st = BSD_TAP_TLR;
        end
        else if (step_in)
        begin
            case (r_ff.st)
                BSD_TAP_TLR: nxt_r.st = tms_in ? BSD_TAP_TLR : BSD_TAP_RTI;
                BSD_TAP_RTI: nxt_r.st = tms_in ? BSD_TAP_SEL_DR : BSD_TAP_RTI;
                BSD_TAP_SEL_DR: nxt_r.st = tms_in ? BSD_TAP_SEL_IR : BSD_TAP_CAP_DR;
                BSD_TAP_CAP_DR: nxt_r.st = tms_in ? BSD_TAP_EX1_DR : BSD_TAP_SH_DR;
                BSD_TAP_SH_DR: nxt_r.st = tms_in ? BSD_TAP_EX1_DR : BSD_TAP_SH_DR;
                BSD_TAP_EX1_DR: nxt_r.st = tms_in ? BSD_TAP_UPD_DR : BSD_TAP_PAU_DR;
                BSD_TAP_PAU_DR: nxt_r.st = tms_in ? BSD_TAP_EX2_DR : BSD_TAP_PAU_DR;
                BSD_TAP_EX2_DR: nxt_r.st = tms_in ? BSD_TAP_UPD_DR : BSD_TAP_SH_DR;
                BSD_TAP_UPD_DR: nxt_r.st = tms_in ? BSD_TAP_SEL_DR : BSD_TAP_RTI;
                BSD_TAP_SEL_IR: nxt_r.st = tms_in ? BSD_TAP_TLR : BSD_TAP_CAP_IR;
                BSD_TAP_CAP_IR: nxt_r.st = tms_in ? BSD_TAP_EX1_IR : BSD_TAP_SH_IR;
                BSD_TAP_SH_IR: nxt_r.st = tms_in ? BSD_TAP_EX1_IR : BSD_TAP_SH_IR;
                BSD_TAP_EX1_IR: nxt_r.st = tms_in ? BSD_TAP_UPD_IR : BSD_TAP_PAU_IR;
                BSD_TAP_PAU_IR: nxt_r.st = tms_in ? BSD_TAP_EX2_IR : BSD_TAP_PAU_IR;
                BSD_TAP_EX2_IR: nxt_r.st = tms_in ? BSD_TAP_UPD_IR : BSD_TAP_SH_IR;
                BSD_TAP_UPD_IR: nxt_r.st = tms_in ? BSD_TAP_SEL_DR : BSD_TAP_RTI;
                default: nxt_r.st = BSD_TAP_TLR;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            r_ff <= '0;
        end
        else if (ce_in)
        begin
            r_ff <= nxt_r;
        end
    end

    assign state_out = r_ff.st;

endmodule

/* test/bsd_jtag_host.sv */
// Test controller model: drives TCK, TMS, TDI and samples TDO
`timescale 1ns/100ps
module bsd_jtag_host
(
    // Link to the device
    output logic tck_out,
    output logic tms_out,
    output logic tdi_out,
    input wire logic tdo_in,
    input wire logic tdo_oe_in
);
    logic oe_seen;

    ////////////////////////////////////////////////////////////////
    // Link rests with TCK low between frames
    initial
    begin
        tck_out = 1'h0;
        tms_out = 1'h1;
        tdi_out = 1'h0;
        oe_seen = 1'h0;
    end

    // One TCK period; TDO taken just before the rise
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tms_out = tms;
        tdi_out = tdi;
        #62.5;
        tdo = tdo_in;
        oe_seen = oe_seen | tdo_oe_in;
        tck_out = 1'h1;
        #62.5;
        tck_out = 1'h0;
    endtask

    // IR or DR scan from Run-Test/Idle back to Run-Test/Idle
    task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        logic b;
        dout = 32'h0;
        step(1'h1, 1'h0, b);
        if (ir)
            step(1'h1, 1'h0, b);
        step(1'h0, 1'h0, b);
        step(1'h0, 1'h0, b);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], b);
            dout[i] = b;
        end
        step(1'h1, 1'h0, b);
        step(1'h0, 1'h0, b);
    endtask
endmodule

/* test/test_bsd_top.sv */
// Self-checking bench for the boundary-scan block
`timescale 1ns/100ps
module test_bsd_top import bsd_pkg::*;;
    localparam logic [3:0] VER = 4'h3;
    localparam logic [15:0] PART = 16'h1234; // Arbitrary value
    localparam logic [10:0] MFR = 11'h0a5; // Arbitrary value
    localparam logic [31:0] IDW = {VER, PART, MFR, 1'h1};
    localparam logic [13:0] PRE = 14'h1035;
    logic clk_in = 1'h0, rst_in = 1'h1, ce = 1'h1, fuse = 1'h1, dis = 1'h0, global_pullup_disable = 1'h0;
    logic rstn = 1'h1, hv = 1'h0, eck = 1'h1, xck = 1'h0, lck = 1'h0;
    logic tck, tms, tdi, tdo, tdo_oe, chip_rst, b;
    logic [1:0] copt = 2'h0, dir = 2'h1, sys_do = 2'h3, pin_in = 2'h2, oe, pdo, pu;
    bsd_osc_t osc_in = 3'h2;
    bsd_osc_t osc_out;
    logic [31:0] rd;
    int fails = 0, comparisons = 0;

    ////////////////////////////////////////////////////////////////
    // Clock, device and controller model
    always #5 clk_in = ~clk_in;
    bsd_top #(.NPIN(2), .ID_VER(VER), .ID_PART(PART), .ID_MFR(MFR), .TOUT_0(16'h0040)) DUT (
        .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
        .tdo_out(tdo), .tdo_oe_out(tdo_oe), .test_port_enable_fuse_in(fuse), .test_port_disable_bit_in(dis),
        .clk_opt_in(copt), .pin_direction_bit_in(dir), .pin_output_bit_in(sys_do),
        .global_pullup_disable_in(global_pullup_disable), .pin_input_bit_in(pin_in), .pin_oe_out(oe), .pin_do_out(pdo),
        .pin_pu_out(pu), .ext_reset_n_in(rstn), .high_voltage_reset_in(hv), .osc_en_in(osc_in),
        .external_clock_line_in(eck), .crystal_oscillator_clock_in(xck), .low_freq_crystal_clock_in(lck),
        .osc_en_out(osc_out), .chip_reset_out(chip_rst));
    bsd_jtag_host u_host (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo), .tdo_oe_in(tdo_oe));

    ////////////////////////////////////////////////////////////////
    // Compare and closing
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // Default identity read, then bypass
    task automatic t_id_byp();
        u_host.scan(1'h0, 32, 32'h0, rd);
        chk(rd, IDW);
        u_host.scan(1'h1, 4, {28'h0, BSD_OP_BYPASS}, rd);
        chk(rd[3:0], 4'h1);
        u_host.scan(1'h0, 3, 32'h7, rd);
        chk(rd[2:0], 3'h6);
    endtask

    // Sample pins and preload latches; pads keep system values
    task automatic t_sample();
        u_host.scan(1'h1, 4, {28'h0, BSD_OP_SAMPLE}, rd);
        u_host.scan(1'h0, 14, {18'h0, PRE}, rd);
        chk(rd[13:0], {1'h1, osc_in.lf_en, xck, osc_in.xtal_en, 1'h0, osc_in.ext_en, hv, rstn, pin_in[1], dir[1],
            ~global_pullup_disable & ~dir[1] & sys_do[1], pin_in[0], dir[0], ~global_pullup_disable & ~dir[0] & sys_do[0]});
        chk({oe, pdo, pu, osc_out}, {dir, sys_do, ~{2{global_pullup_disable}} & ~dir & sys_do, osc_in});
    endtask

    // Latches reach the pads on EXTEST; capture sees the pins
    task automatic t_extest();
        u_host.scan(1'h1, 4, {28'h0, BSD_OP_EXTEST}, rd);
        chk({oe, pdo, pu, osc_out}, {2'h2, 2'h3, 2'h1, 3'h1});
        @(posedge clk_in);
        pin_in <= 2'h1;
        #1;
        u_host.scan(1'h0, 14, {18'h0, 14'h100a}, rd);
        chk({rd[5], rd[2]}, 2'h1);
        chk({oe, pdo, pu, osc_out}, {2'h1, 2'h0, 2'h2, 3'h1});
    endtask

    // Reset register: immediate hold, shift-only, then time-out
    task automatic t_reset();
        u_host.scan(1'h1, 4, {28'h0, BSD_OP_CHIP_RESET}, rd);
        u_host.scan(1'h0, 1, 32'h1, rd);
        repeat (2) @(posedge clk_in);
        #1;
        chk(chip_rst, 1'h1);
        chk(oe, 2'h0);
        u_host.scan(1'h0, 1, 32'h0, rd);
        chk(rd[0], 1'h1);
        chk(chip_rst, 1'h1);
        repeat (70) @(posedge clk_in);
        #1;
        chk(chip_rst, 1'h0);
    endtask

    // Disabled port never drives TDO and returns to identity
    task automatic t_disable();
        @(posedge clk_in);
        dis <= 1'h1;
        u_host.oe_seen = 1'h0;
        #1;
        u_host.scan(1'h1, 4, {28'h0, BSD_OP_BYPASS}, rd);
        chk(u_host.oe_seen, 1'h0);
        @(posedge clk_in);
        dis <= 1'h0;
        repeat (4) @(posedge clk_in);
        #1;
        u_host.step(1'h0, 1'h0, b);
        u_host.scan(1'h0, 32, 32'h0, rd);
        chk(rd, IDW);
    endtask

    ////////////////////////////////////////////////////////////////
    // Main sequence and watchdog
    initial
    begin
        repeat (4) @(posedge clk_in);
        rst_in <= 1'h0;
        repeat (100) @(posedge clk_in);
        #1;
        u_host.step(1'h0, 1'h0, b);
        t_id_byp();
        t_sample();
        t_extest();
        t_reset();
        t_disable();
        end_of_test();
    end

    initial
    begin
        #300000;
        fails++;
        end_of_test();
    end
endmodule
